// file: inc/mfp_pkg.sv
// Constants shared by the multi-function I/O port block.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package mfp_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_OUT    = 8'h00;
    localparam logic [7:0] OFF_IN     = 8'h04;
    localparam logic [7:0] OFF_DIR    = 8'h08;
    localparam logic [7:0] OFF_OPEN   = 8'h0C;
    localparam logic [7:0] OFF_PULLUP = 8'h10;
    localparam logic [7:0] OFF_ANA    = 8'h14;
    localparam logic [7:0] OFF_FUNC   = 8'h18;
    localparam logic [7:0] OFF_SYNC   = 8'h1C;
    // ------------------------------------------------------------
    // Function-enable register fields
    // ------------------------------------------------------------
    localparam int FB_PWM0  = 0;
    localparam int FB_PWM1  = 1;
    localparam int FB_CPUCK = 2;
    localparam int FB_SLOW  = 3;
    localparam int FB_SYNC  = 4;
    localparam int FB_TX    = 5;
    localparam int FB_RX    = 6;
    localparam int FB_CKSEL = 7;
    // Sync-serial register fields
    localparam int SB_L0VAL = 0;
    localparam int SB_L1VAL = 1;
    localparam int SB_L0OUT = 2;
    localparam int SB_L1OUT = 3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_OUT    = 8'h00;
    localparam logic [7:0] RST_DIR    = 8'h00;
    localparam logic [7:0] RST_OPEN   = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'hFF;
    localparam logic [7:0] RST_ANA    = 8'h00;
    localparam logic [7:0] RST_FUNC   = 8'h00;
    localparam logic [3:0] RST_SYNC   = 4'h0;
    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DATA = 2'b10
    } mfp_bus_t;
endpackage

// file: verilog/mfp_sync8.sv
// Two-flop synchroniser for the eight pad input levels.
// Assumes pads are asynchronous to mclk.
`timescale 1ns/100ps
`default_nettype none
module mfp_sync8 (
    input  wire logic       mclk,   // System clock
    input  wire logic       reset,  // Sync reset, active high
    input  wire logic [7:0] din,    // Asynchronous levels
    output logic      [7:0] dout    // Synchronised levels
);
    import mfp_pkg::*;

    typedef struct packed {
        logic [7:0] s1;
        logic [7:0] s2;
    } mfp_sync_t;

    mfp_sync_t st_reg;
    mfp_sync_t st_next;

    always_comb
    begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.s2;
endmodule
`default_nettype wire

// file: verilog/mfp_port.sv
// Eight-pad multi-function I/O port with AHB-Lite register access.
// Assumes peripheral function signals are on mclk; pads and the
// power-on reset level are asynchronous and are synchronised here.
//
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE1: PWM channel 0/1 enabled drives its waveform on pad 0/1.
// RULE2: Software sets pad 0/1 direction itself when using PWM.
// RULE3: Slow clock enable puts the 16 kHz clock on pad 3.
// RULE4: CPU clock enable puts the CPU clock on pad 2.
// RULE5: CPU clock select picks which source clock feeds pad 2.
// RULE6: Sync serial enable makes pads 4 and 5 open-drain serial lines.
// RULE7: Output lines 0/1 drive pad 4/5 from their value bits.
// RULE8: Software enables pads 4/5 pull-ups without external resistors.
// RULE9: Serial transmit drives pad 6; receive takes pad 7 as input.
// RULE10: Direction 1 enables output buffer; 0 leaves pad input-only.
// RULE11: Configuration reset clears direction and output-value bits.
// RULE12: Input register returns pad levels without debounce.
// RULE13: Input read shows real pin level even in output mode.
// RULE14: Output pad drives its output-value bit unless overridden.
// RULE15: Open-drain drives low for 0, releases for 1; resets push-pull.
// RULE16: Per-pad pull-up enable bits reset to one.
// RULE17: Pull-up only for inputs or open-drain outputs released high.
// RULE18: Pad 1 pulled down during power-on reset, up afterwards.
// RULE19: Input buffer enabled except in analog mode.
// RULE20: Software puts comparator pads 4 to 7 in unconnected analog mode.
// RULE21: Software orders pull-up, analog, line select, pull-up writes.
// RULE22: Analog mode: direction and value pick line, pull-up connects.
// RULE23: Analog beats peripheral function, which beats digital settings.
// RULE24: Configuration bits update on the accepted write's clock edge.
module mfp_port (
    input  wire logic        mclk,          // System clock, 200 MHz
    input  wire logic        reset,         // Sync reset, active high
    input  wire logic        hsel,          // AHB slave select
    input  wire logic [7:0]  haddr,         // AHB address, low byte
    input  wire logic [1:0]  htrans,        // AHB transfer type
    input  wire logic        hwrite,        // AHB write
    input  wire logic [2:0]  hsize,         // AHB size
    input  wire logic [31:0] hwdata,        // AHB write data
    input  wire logic        hready,        // AHB bus ready
    output logic      [31:0] hrdata,        // AHB read data
    output logic             hreadyout,     // AHB slave ready
    output logic             hresp,         // AHB response, OKAY
    input  wire logic [7:0]  padIn,         // Pad levels from pins
    output logic      [7:0]  padOut,        // Pad output levels
    output logic      [7:0]  padOe,         // Pad output enables
    output logic      [7:0]  padPullUp,     // Pull-up connected
    output logic      [7:0]  padPullDown,   // Pull-down connected
    output logic      [7:0]  padInEn,       // Input buffer enable
    output logic      [7:0]  padAnaConnect, // Pad on analog line
    output logic      [15:0] padAnaLine,    // Line number, 2 bits/pad
    input  wire logic        porActive,     // Power-on reset level
    input  wire logic        pwmWave0,      // PWM channel 0 waveform
    input  wire logic        pwmWave1,      // PWM channel 1 waveform
    input  wire logic        slowClock,     // 16 kHz clock
    input  wire logic        cpuClockFast,  // Clock for select 0
    input  wire logic        cpuClockSlow,  // Clock for select 1
    input  wire logic        serialTx,      // Serial transmit data
    output logic             serialRx,      // Serial receive data
    output logic             syncLine0In,   // Sync line 0 from pad 4
    output logic             syncLine1In    // Sync line 1 from pad 5
);
    import mfp_pkg::*;

    typedef struct packed {
        mfp_bus_t   bus;
        logic [7:0] addr;
        logic       wr;

        logic [7:0] padOutputValue;
        logic [7:0] padDirection;
        logic [7:0] padOpenDrain;
        logic [7:0] padPullupEnable;
        logic [7:0] padAnalogSelect;
        logic [7:0] func;
        logic [3:0] sync;
        logic       porS1;
        logic       porS2;

        logic [31:0] rdata;

        logic [7:0] oOut;
        logic [7:0] oOe;
        logic [7:0] oPu;
        logic [7:0] oPd;
        logic [7:0] oInEn;
        logic [7:0] oAnaCon;
        logic [15:0] oAnaLine;
        logic       oRx;
        logic       oL0;
        logic       oL1;
    } mfp_state_t;

    mfp_state_t st_reg;
    mfp_state_t st_next;
    logic [7:0] padSync;

    mfp_sync8 u_sync (
        .mclk  (mclk),
        .reset (reset),
        .din   (padIn),
        .dout  (padSync)
    );

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    function automatic logic [31:0] readReg(input mfp_state_t s, input logic [7:0] a,
                                            input logic [7:0] pins);
        logic [31:0] r;
        r = 32'h0000_0000;
        if (a == OFF_OUT)
            r[7:0] = s.padOutputValue;
        else if (a == OFF_IN)
            r[7:0] = pins; // RULE12 RULE13
        else if (a == OFF_DIR)
            r[7:0] = s.padDirection;
        else if (a == OFF_OPEN)
            r[7:0] = s.padOpenDrain;
        else if (a == OFF_PULLUP)
            r[7:0] = s.padPullupEnable;
        else if (a == OFF_ANA)
            r[7:0] = s.padAnalogSelect;
        else if (a == OFF_FUNC)
            r[7:0] = s.func;
        else if (a == OFF_SYNC)
            r[3:0] = s.sync;
        return r;
    endfunction

    logic       po;
    logic       oe;
    logic       od;
    logic       fn;
    logic       takeReq;

    always_comb
    begin
        st_next = st_reg;
        po = 1'b0;
        oe = 1'b0;
        od = 1'b0;
        fn = 1'b0;
        // Only whole-word single transfers are mapped
        takeReq = hsel && hready && (htrans == HTRANS_NONSEQ)
                  && (hsize == HSIZE_WORD);
        // ------------------------------------------------------------
        // Bus slave: zero wait states, data phase one cycle after address
        // ------------------------------------------------------------
        case (st_reg.bus)
            ST_IDLE:
            begin
                st_next.bus = ST_IDLE;
            end
            ST_DATA:
            begin
                st_next.bus = ST_IDLE;
                if (st_reg.wr)
                begin
                    // RULE24
                    if (st_reg.addr == OFF_OUT)
                        st_next.padOutputValue = hwdata[7:0];
                    else if (st_reg.addr == OFF_DIR)
                        st_next.padDirection = hwdata[7:0];
                    else if (st_reg.addr == OFF_OPEN)
                        st_next.padOpenDrain = hwdata[7:0];
                    else if (st_reg.addr == OFF_PULLUP)
                        st_next.padPullupEnable = hwdata[7:0];
                    else if (st_reg.addr == OFF_ANA)
                        st_next.padAnalogSelect = hwdata[7:0];
                    else if (st_reg.addr == OFF_FUNC)
                        st_next.func = hwdata[7:0];
                    else if (st_reg.addr == OFF_SYNC)
                        st_next.sync = hwdata[3:0];
                end
            end
            default:
            begin
                st_next.bus = ST_IDLE;
            end
        endcase
        if (takeReq)
        begin
            st_next.bus   = ST_DATA;
            st_next.addr  = {haddr[7:2], 2'b00};
            st_next.wr    = hwrite;
            // Writes leave the last read data standing
            if (!hwrite)
            begin
                st_next.rdata = readReg(st_reg, {haddr[7:2], 2'b00}, padSync);
            end
        end
        // Power-on reset level is asynchronous
        st_next.porS1 = porActive;
        st_next.porS2 = st_reg.porS1;

        // ------------------------------------------------------------
        // Pad muxing, one pad at a time
        // ------------------------------------------------------------
        for (int i = 0; i < 8; i++)
        begin
            po = st_reg.padOutputValue[i];   // RULE14
            oe = st_reg.padDirection[i];     // RULE10
            od = st_reg.padOpenDrain[i];
            fn = 1'b0;
            // RULE23: functions override digital settings
            if (i == 0 && st_reg.func[FB_PWM0])
            begin
                po = pwmWave0; // RULE1
                fn = 1'b1;
            end

            if (i == 1 && st_reg.func[FB_PWM1])
            begin
                po = pwmWave1; // RULE1
                fn = 1'b1;
            end

            if (i == 2 && st_reg.func[FB_CPUCK])
            begin
                // RULE4 RULE5
                po = st_reg.func[FB_CKSEL] ? cpuClockSlow : cpuClockFast;
                fn = 1'b1;
            end

            if (i == 3 && st_reg.func[FB_SLOW])
            begin
                po = slowClock; // RULE3
                fn = 1'b1;
            end

            if (i == 4 && st_reg.func[FB_SYNC])
            begin
                // RULE6 RULE7
                od = 1'b1;
                oe = st_reg.sync[SB_L0OUT];
                po = st_reg.sync[SB_L0VAL];
                fn = 1'b1;
            end

            if (i == 5 && st_reg.func[FB_SYNC])
            begin
                // RULE6 RULE7
                od = 1'b1;
                oe = st_reg.sync[SB_L1OUT];
                po = st_reg.sync[SB_L1VAL];
                fn = 1'b1;
            end

            if (i == 6 && st_reg.func[FB_TX])
            begin
                oe = 1'b1; // RULE9
                od = 1'b0;
                po = serialTx;
                fn = 1'b1;
            end

            if (i == 7 && st_reg.func[FB_RX])
            begin
                oe = 1'b0; // RULE9
                fn = 1'b1;
            end

            if (st_reg.padAnalogSelect[i])
            begin
                // RULE22 RULE23: analog overrides everything
                st_next.oOut[i]    = 1'b0;
                st_next.oOe[i]     = 1'b0;
                st_next.oPu[i]     = 1'b0;
                st_next.oPd[i]     = 1'b0;
                st_next.oInEn[i]   = 1'b0; // RULE19
                st_next.oAnaCon[i] = st_reg.padPullupEnable[i];
                st_next.oAnaLine[2*i +: 2] = {st_reg.padDirection[i],
                                              st_reg.padOutputValue[i]};
            end
            else
            begin
                st_next.oInEn[i]   = 1'b1; // RULE19
                st_next.oAnaCon[i] = 1'b0;
                st_next.oAnaLine[2*i +: 2] = 2'b00;
                // Open-drain only ever drives low; the enable carries data
                st_next.oOut[i] = od ? 1'b0 : po; // RULE15
                st_next.oOe[i]  = oe && !(od && po); // RULE10 RULE15
                // RULE17: no pull-up while pad is actively driven
                st_next.oPu[i]  = st_reg.padPullupEnable[i]
                                  && (!oe || (od && po));
                st_next.oPd[i]  = 1'b0;
                if (i == 1 && st_reg.porS2)
                begin
                    st_next.oPu[i] = 1'b0; // RULE18
                    st_next.oPd[i] = 1'b1; // RULE18
                end
            end

            if (fn && i == 0)
                st_next.oOut[i] = st_next.oOut[i];
        end
        // Function inputs: pads read even while driving
        st_next.oRx = st_reg.func[FB_RX] ? padSync[7] : 1'b1; // RULE9
        st_next.oL0 = padSync[4];
        st_next.oL1 = padSync[5];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            // RULE11 RULE16
            st_reg                 <= '0;
            st_reg.bus             <= ST_IDLE;
            st_reg.padOutputValue  <= RST_OUT;
            st_reg.padDirection    <= RST_DIR;
            st_reg.padOpenDrain    <= RST_OPEN; // RULE15
            st_reg.padPullupEnable <= RST_PULLUP;
            st_reg.padAnalogSelect <= RST_ANA;
            st_reg.func            <= RST_FUNC;
            st_reg.sync            <= RST_SYNC;
            st_reg.oInEn           <= 8'hFF;
            st_reg.oPu             <= 8'hFF;
            st_reg.oRx             <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign hrdata        = st_reg.rdata;
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign padOut        = st_reg.oOut;
    assign padOe         = st_reg.oOe;
    assign padPullUp     = st_reg.oPu;
    assign padPullDown   = st_reg.oPd;
    assign padInEn       = st_reg.oInEn;
    assign padAnaConnect = st_reg.oAnaCon;
    assign padAnaLine    = st_reg.oAnaLine;
    assign serialRx      = st_reg.oRx;
    assign syncLine0In   = st_reg.oL0;
    assign syncLine1In   = st_reg.oL1;
endmodule
`default_nettype wire

// file: sim/mfp_port_chk.sv
// Concurrent checks on the pins and bus of the I/O port.
// Assumes binding to mfp_port; mclk is the only clock.
`timescale 1ns/100ps
`default_nettype none
module mfp_port_chk
    import mfp_pkg::*;
(
    input wire logic        mclk,          // Clock
    input wire logic        reset,         // Sync reset
    input wire logic        hsel,          // Select
    input wire logic [7:0]  haddr,         // Address
    input wire logic [1:0]  htrans,        // Transfer type
    input wire logic        hwrite,        // Write
    input wire logic        hready,        // Bus ready
    input wire logic [31:0] hrdata,        // Read data
    input wire logic [7:0]  padIn,         // Pin levels
    input wire logic [7:0]  padOut,        // Drive value
    input wire logic [7:0]  padOe,         // Drive enable
    input wire logic [7:0]  padPullUp,     // Pull-up on
    input wire logic [7:0]  padPullDown,   // Pull-down on
    input wire logic [7:0]  padInEn,       // Input buffer on
    input wire logic [7:0]  padAnaConnect, // On analog line
    input wire logic        porActive,     // Power-on level
    input wire logic        serialRx,      // Receive data
    input wire logic        syncLine0In,   // Sync line 0
    input wire logic        syncLine1In    // Sync line 1
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // Sequences and properties
    // ----------------------------------------
    // Five quiet cycles cover the two sync flops and the output stage
    sequence s_quiet;
        (!reset && $stable(padIn)) [*5];
    endsequence
    sequence s_rd_in;
        hsel && hready && htrans == HTRANS_NONSEQ && !hwrite && haddr == OFF_IN;
    endsequence
    property p_rst_state;
        $fell(reset) |-> padOe == 8'h00 && padOut == 8'h00 && padInEn == 8'hFF;
    endproperty
    property p_pu_drive;
        (padPullUp & padOe) == 8'h00;
    endproperty
    property p_pd_only;
        (padPullDown & 8'hFD) == 8'h00 && !(padPullDown[1] && padPullUp[1]);
    endproperty
    property p_por_on;
        (!reset && porActive) [*4] |-> padPullDown[1] && !padPullUp[1];
    endproperty
    property p_por_off;
        (!reset && !porActive) [*4] |-> !padPullDown[1];
    endproperty
    property p_ana;
        (padAnaConnect & (padInEn | padOe | padPullUp)) == 8'h00;
    endproperty
    property p_sync_lines;
        s_quiet |-> syncLine0In == padIn[4] && syncLine1In == padIn[5];
    endproperty
    property p_rx;
        s_quiet ##0 !serialRx |-> !padIn[7];
    endproperty
    property p_rd_in;
        s_quiet ##0 s_rd_in |=> hrdata[7:0] == $past(padIn);
    endproperty
    property p_hold;
        !(hsel && hready && htrans == HTRANS_NONSEQ && !hwrite) |=> $stable(hrdata);
    endproperty
    a_rst_state: assert property (p_rst_state)
        else $error("pads not idle after reset");
    a_pu_drive: assert property (p_pu_drive)
        else $error("pull-up on a driven pad");
    a_pd_only: assert property (p_pd_only)
        else $error("pull-down on wrong pad");
    a_por_on: assert property (p_por_on)
        else $error("pad 1 not pulled down in power-on");
    a_por_off: assert property (p_por_off)
        else $error("pad 1 pull-down stuck");
    a_ana: assert property (p_ana)
        else $error("analog pad still digital");
    a_sync_lines: assert property (p_sync_lines)
        else $error("sync line input wrong");
    a_rx: assert property (p_rx)
        else $error("receive low with pin high");
    a_rd_in: assert property (p_rd_in)
        else $error("input read wrong");
    a_hold: assert property (p_hold)
        else $error("read data moved");
endmodule
bind mfp_port mfp_port_chk chk (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hrdata, .padIn, .padOut, .padOe, .padPullUp, .padPullDown, .padInEn, .padAnaConnect,
    .porActive, .serialRx, .syncLine0In, .syncLine1In);
`default_nettype wire

// file: sim/mfp_pads.sv
// Pins and peripheral sources around the I/O port.
// Assumes the bench drives extEn/extVal just after mclk edges.
`timescale 1ns/100ps
`default_nettype none
module mfp_pads (
    input  wire logic       mclk,         // Clock
    input  wire logic [7:0] padOut,       // Port drive value
    input  wire logic [7:0] padOe,        // Port drive enable
    input  wire logic [7:0] padPullUp,    // Pull-up on
    input  wire logic [7:0] padPullDown,  // Pull-down on
    input  wire logic [7:0] extEn,        // Outside drive on
    input  wire logic [7:0] extVal,       // Outside level
    output logic      [7:0] padIn,        // Resolved pin level
    output logic            pwmWave0,     // PWM 0
    output logic            pwmWave1,     // PWM 1
    output logic            slowClock,    // Slow clock
    output logic            cpuClockFast, // Fast CPU clock
    output logic            cpuClockSlow, // Slow CPU clock
    output logic            serialTx      // Transmit data
);
    logic [5:0] cnt = 6'h00;
    // ----------------------------------------
    // Sources and pin resolution
    // ----------------------------------------
    always @(posedge mclk)
        cnt <= cnt + 6'h01;
    assign cpuClockFast = cnt[0];
    assign pwmWave0     = cnt[1];
    assign pwmWave1     = cnt[2];
    assign cpuClockSlow = cnt[3];
    assign serialTx     = cnt[4];
    assign slowClock    = cnt[5];
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (extEn[i])
                padIn[i] = extVal[i];
            else if (padOe[i])
                padIn[i] = padOut[i];
            else if (padPullUp[i] || padPullDown[i])
                padIn[i] = padPullUp[i];
            else
                padIn[i] = cnt[0]; // Floating pin wanders, never a held level
        end
    end
endmodule
`default_nettype wire

// file: sim/mfp_port_tb_top.sv
// Self-checking bench for the multi-function I/O port.
// Assumes mfp_port, mfp_pads and the bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none
module mfp_port_tb_top;
    import mfp_pkg::*;
    logic        mclk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, porActive = 1'b0;
    logic [7:0]  haddr = 8'h00, extEn = 8'h00, extVal = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = HSIZE_WORD;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, serialRx, syncLine0In, syncLine1In;
    logic        pwmWave0, pwmWave1, slowClock, cpuClockFast, cpuClockSlow, serialTx;
    logic [7:0]  padIn, padOut, padOe, padPullUp, padPullDown, padInEn, padAnaConnect;
    logic [15:0] padAnaLine;
    logic [4:0]  pv;
    int          error_cnt = 0, compares = 0, cyc = 0;
    logic [7:0]  offs [7] = '{OFF_OUT, OFF_DIR, OFF_OPEN, OFF_PULLUP, OFF_ANA, OFF_FUNC, OFF_SYNC};
    logic [7:0]  rstv [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    // Out dir open pull ana func sync | oe drive pull inEn anaConnect
    logic [95:0] rows [7] = '{96'h050F00FF0000000F05F0FF00, 96'h0FFFFF3C000000F0000CFF00,
        96'hC0A00000F000000000000F00, 96'hFF0000FF00100D2000DFFF00,
        96'h000000FF0300000000FCFC03, 96'h808000FF0040000000FFFF00,
        96'h00010000010100000000FE00};

    always #2.5 mclk = ~mclk;

    mfp_port dut (.mclk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .padIn, .padOut, .padOe, .padPullUp,
        .padPullDown, .padInEn, .padAnaConnect, .padAnaLine, .porActive, .pwmWave0, .pwmWave1,
        .slowClock, .cpuClockFast, .cpuClockSlow, .serialTx, .serialRx, .syncLine0In,
        .syncLine1In);
    mfp_pads pads (.mclk, .padOut, .padOe, .padPullUp, .padPullDown, .extEn, .extVal, .padIn,
        .pwmWave0, .pwmWave1, .slowClock, .cpuClockFast, .cpuClockSlow, .serialTx);

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, offs[i], 32'h0);
            chk("reset value", rd, {24'h0, rstv[i]});
        end
        bus(1'b1, 8'h20, 32'hFFFFFFFF);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        porActive <= 1'b1;
        repeat (6) @(posedge mclk);
        chk("por pulls", {16'h0, padPullDown, padPullUp}, 32'h02FD);
        porActive <= 1'b0;
        repeat (6) @(posedge mclk);
        chk("por done", {16'h0, padPullDown, padPullUp}, 32'h00FF);
        extEn <= 8'hFF;
        extVal <= 8'hA5;
        repeat (5) @(posedge mclk);
        bus(1'b0, OFF_IN, 32'h0);
        chk("pin read", rd, 32'hA5);
        bus(1'b1, OFF_OUT, 32'h0F);
        bus(1'b1, OFF_DIR, 32'hFF);
        extEn <= 8'h01;
        extVal <= 8'h00;
        repeat (6) @(posedge mclk);
        bus(1'b0, OFF_IN, 32'h0);
        chk("read back", rd, 32'h0E);
        bus(1'b1, OFF_FUNC, 32'h40);
        extEn <= 8'h81;
        for (int v = 0; v < 2; v++)
        begin
            extVal <= {v[0], 7'h00};
            repeat (6) @(posedge mclk);
            chk("rx", {31'h0, serialRx}, {31'h0, v[0]});
        end
        extEn <= 8'h00;
        for (int i = 0; i < 7; i++)
        begin
            for (int j = 0; j < 7; j++)
                bus(1'b1, offs[j], {24'h0, rows[i][95-8*j -: 8]});
            repeat (2) @(posedge mclk);
            chk("oe", {24'h0, padOe}, {24'h0, rows[i][39:32]});
            chk("drive", {24'h0, padOut & padOe}, {24'h0, rows[i][31:24]});
            chk("pull", {24'h0, padPullUp}, {24'h0, rows[i][23:16]});
            chk("in en", {24'h0, padInEn}, {24'h0, rows[i][15:8]});
            chk("ana", {24'h0, padAnaConnect}, {24'h0, rows[i][7:0]});
            bus(1'b0, OFF_DIR, 32'h0);
            chk("dir", rd, {24'h0, rows[i][87:80]});
        end
        bus(1'b1, OFF_PULLUP, 32'h0);
        bus(1'b1, OFF_ANA, 32'h42);
        bus(1'b1, OFF_DIR, 32'h42);
        bus(1'b1, OFF_OUT, 32'h40);
        bus(1'b1, OFF_PULLUP, 32'h42);
        repeat (2) @(posedge mclk);
        chk("ana line", {padAnaLine, 8'h0, padAnaConnect}, 32'h30080042);
        bus(1'b1, OFF_ANA, 32'h0);
        for (int s = 0; s < 2; s++)
        begin
            bus(1'b1, OFF_DIR, 32'h0F);
            bus(1'b1, OFF_FUNC, {24'h0, s[0], 7'h2F});
            repeat (3) @(posedge mclk);
            for (int k = 0; k < 8; k++)
            begin
                pv = {serialTx, slowClock, s[0] ? cpuClockSlow : cpuClockFast, pwmWave1, pwmWave0};
                @(posedge mclk);
                chk("fn", {27'h0, padOut[6], padOut[3:0]}, {27'h0, pv});
            end
            chk("fn oe", {24'h0, padOe}, 32'h4F);
        end
        bus(1'b1, OFF_OUT, 32'hFF);
        reset <= 1'b1;
        repeat (3) @(posedge mclk);
        reset <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("oe reset", {24'h0, padOe}, 32'h0);
        bus(1'b0, OFF_OUT, 32'h0);
        chk("out reset", rd, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
